// [hw/fmul_pkg.sv]
// constants, enumerations and carriers of the fraction multiply sequencer
package fmul_pkg;

    // register and window geometry
    localparam int REG_W       = 60;
    localparam int WIN_W       = 7;
    localparam int SHIFT_W     = 3;
    localparam int SC_W        = 8;
    localparam int MAX_SHIFT_N = 6;
    localparam int SP_WIN_LSB  = 35;
    localparam int DP_WIN_LSB  = 3;
    localparam int CYC_W       = 6;

    localparam logic [SHIFT_W-1:0] MAX_SHIFT = 3'h6;
    localparam logic [SHIFT_W-1:0] ONE_SHIFT = 3'h1;

    // multiplier lengths in bits and their negated step counter loads
    localparam logic [SC_W-1:0] SP_LEN     = 8'h18;
    localparam logic [SC_W-1:0] DP_LEN     = 8'h38;
    localparam logic [SC_W-1:0] SP_SC_INIT = 8'he8;
    localparam logic [SC_W-1:0] DP_SC_INIT = 8'hc8;
    localparam logic [SC_W-1:0] SC_ZERO    = 8'h00;

    localparam logic [REG_W-1:0] WORD_ZERO = 60'h0;
    localparam logic [REG_W-1:0] WORD_ONE  = 60'h1;
    localparam logic [CYC_W-1:0] CYC_ZERO  = 6'h00;
    localparam logic [CYC_W-1:0] CYC_ONE   = 6'h01;

    // arithmetic operation chosen for one step
    typedef enum logic [1:0] {
        OP_NONE = 2'h0,
        OP_ADD  = 2'h1,
        OP_SUB  = 2'h2
    } arith_op_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h1,
        ST_RUN    = 3'h2,
        ST_FINISH = 3'h4
    } seq_state_t;

    // operands handed over at start
    typedef struct packed {
        logic             dbl;
        logic [REG_W-1:0] multiplicand;
        logic [REG_W-1:0] multiplier;
    } mul_req_t;

    // result handed back at done
    typedef struct packed {
        logic [REG_W-1:0] product;
        logic             exp_dec;
        logic [SC_W-1:0]  final_count;
    } mul_rsp_t;

    // decision of one recoding encoder
    typedef struct packed {
        logic [SHIFT_W-1:0] shift;
        arith_op_t          op;
        logic               next_sub;
    } recode_t;

endpackage

// [hw/recode_encoder.sv]
// recoding encoder: shift count and operation from a seven bit multiplier window
`timescale 1ns/10ps
module recode_encoder
    import fmul_pkg::*;
(
    input  wire logic [WIN_W-1:0] window,
    input  wire logic             prev_sub,
    output recode_t               decision
);

    // bits that differ from the current string show where it breaks
    wire logic [WIN_W-1:0] diff = window ^ {WIN_W{prev_sub}};

    logic               found;
    logic [SHIFT_W-1:0] pos;
    logic               beyond;

    // lowest break among the six lower bits; the top bit alone is undecidable
    // bit just above the break tells isolated bit from string change
    always_comb begin
        found  = 1'b0;
        pos    = MAX_SHIFT;
        beyond = 1'b0;
        for (int i = 0; i < WIN_W - 1; i++) begin
            if (!found && diff[i]) begin
                found  = 1'b1;
                pos    = SHIFT_W'(i);
                beyond = diff[i + 1]; // index stays inside the window
            end
        end
    end

    always_comb begin
        decision.shift    = MAX_SHIFT;
        decision.op       = OP_NONE;
        decision.next_sub = prev_sub;
        if (!found) begin
            // whole string or lone top break: full shift, no arithmetic
            decision.shift    = MAX_SHIFT;
            decision.op       = OP_NONE;
            decision.next_sub = prev_sub;
        end else begin
            decision.shift = pos + ONE_SHIFT;
            if (!beyond) begin
                // isolated one in zeros adds, isolated zero in ones subtracts
                decision.op       = prev_sub ? OP_SUB : OP_ADD;
                decision.next_sub = prev_sub;
            end else begin
                // string change: zeros to ones subtracts, ones to zeros adds
                decision.op       = prev_sub ? OP_ADD : OP_SUB;
                decision.next_sub = ~prev_sub;
            end
        end
    end

endmodule

// [hw/fraction_multiply_sequencer.sv]
// fraction multiply sequencer: shift over ones and zeros datapath and control
`timescale 1ns/10ps

module fraction_multiply_sequencer
    import fmul_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             start,
    input  wire logic             abort,
    input  mul_req_t              req,
    output logic                  busy,
    output logic                  done,
    output mul_rsp_t              rsp,
    output logic                  string_ones,
    output logic [CYC_W-1:0]      cycle_count
);

    // datapath registers
    seq_state_t           state;
    seq_state_t           next_state;
    logic [REG_W-1:0]     multiplier_shift_reg;
    logic [REG_W-1:0]     partial_product_reg;
    logic [REG_W-1:0]     multiplicand;
    logic [SC_W-1:0]      step_counter;
    logic                 prev_sub;
    logic                 dbl;
    logic [CYC_W-1:0]     cycles;

    // recoding decisions
    recode_t              dec_single;
    recode_t              dec_double;
    recode_t              dec;

    // step datapath wires
    wire logic [WIN_W-1:0]           win_single;
    wire logic [WIN_W-1:0]           win_double;
    wire logic [SHIFT_W-1:0]         shift;
    wire logic [REG_W+MAX_SHIFT_N-1:0] ar_ext;
    wire logic [REG_W+MAX_SHIFT_N-1:0] ar_ext_shifted;
    wire logic [REG_W-1:0]           ar_shifted;
    wire logic [REG_W-1:0]           mcand_neg;
    wire logic [REG_W-1:0]           fraction_operand_mux;
    wire logic [REG_W-1:0]           next_partial;
    wire logic [REG_W-1:0]           next_multiplier;
    wire logic [SC_W-1:0]            next_count;
    wire logic                       count_nonneg;
    wire logic                       step_last;
    wire logic                       count_zero;
    wire logic [SC_W-1:0]            sc_init;
    wire logic                       take_start;

    // a new multiply is taken only while idle
    assign take_start = start && (state == ST_IDLE);

    // windows of both precisions feed their own encoders
    assign win_single = multiplier_shift_reg[SP_WIN_LSB +: WIN_W];
    assign win_double = multiplier_shift_reg[DP_WIN_LSB +: WIN_W];

    recode_encoder enc_single (
        .window   (win_single),
        .prev_sub (prev_sub),
        .decision (dec_single)
    );

    recode_encoder enc_double (
        .window   (win_double),
        .prev_sub (prev_sub),
        .decision (dec_double)
    );

    // precision picks the encoder whose window sits under the fraction
    assign dec   = dbl ? dec_double : dec_single;
    assign shift = dec.shift;

    // multiplier shifts right, zeros enter above its top bit
    assign next_multiplier = multiplier_shift_reg >> shift;

    // accumulator shifts by the same count, filled by the previous operation
    assign ar_ext         = {{MAX_SHIFT_N{prev_sub}}, partial_product_reg};
    assign ar_ext_shifted = ar_ext >> shift;
    assign ar_shifted     = ar_ext_shifted[REG_W-1:0];

    // operand mux: multiplicand, its two's complement, or nothing
    assign mcand_neg = ~multiplicand + WORD_ONE;
    assign fraction_operand_mux = (dec.op == OP_ADD) ? multiplicand :
                                  (dec.op == OP_SUB) ? mcand_neg : WORD_ZERO;

    // shift and arithmetic land in the same cycle
    assign next_partial = ar_shifted + fraction_operand_mux;

    // step counter grows by the bits shifted out
    assign next_count   = step_counter + {{(SC_W-SHIFT_W){1'b0}}, shift};
    assign count_nonneg = ~next_count[SC_W-1];

    // last step: multiplier used up and no string of ones left open
    assign step_last  = count_nonneg && !dec.next_sub;
    assign count_zero = (step_counter == SC_ZERO);

    // step counter load per precision
    assign sc_init = req.dbl ? DP_SC_INIT : SP_SC_INIT;

    // sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (abort) begin
                    next_state = ST_IDLE;
                end else if (step_last) begin
                    next_state = ST_FINISH;
                end
            end
            ST_FINISH: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // operand capture at start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            multiplicand <= WORD_ZERO;
            dbl          <= 1'b0;
        end else if (take_start) begin
            multiplicand <= req.multiplicand;
            dbl          <= req.dbl;
        end
    end

    // multiplier register: load at start, shift each run step
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            multiplier_shift_reg <= WORD_ZERO;
        end else if (take_start) begin
            multiplier_shift_reg <= req.multiplier;
        end else if (state == ST_RUN) begin
            multiplier_shift_reg <= next_multiplier;
        end
    end

    // accumulator: clear at start, shift and add each run step
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            partial_product_reg <= WORD_ZERO;
        end else if (take_start) begin
            partial_product_reg <= WORD_ZERO;
        end else if (state == ST_RUN) begin
            partial_product_reg <= next_partial;
        end
    end

    // step counter and string state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            step_counter <= SC_ZERO;
            prev_sub     <= 1'b0;
        end else if (take_start) begin
            step_counter <= sc_init;
            prev_sub     <= 1'b0;
        end else if (state == ST_RUN) begin
            step_counter <= next_count;
            prev_sub     <= dec.next_sub;
        end
    end

    // run cycle counter, saturating
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycles <= CYC_ZERO;
        end else if (take_start) begin
            cycles <= CYC_ZERO;
        end else if (state == ST_RUN && cycles != {CYC_W{1'b1}}) begin
            cycles <= cycles + CYC_ONE;
        end
    end

    // result: normalize and flag exponent when the counter ended at zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp.product     <= WORD_ZERO;
            rsp.exp_dec     <= 1'b0;
            rsp.final_count <= SC_ZERO;
            done            <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state == ST_FINISH) begin
                done            <= 1'b1;
                rsp.final_count <= step_counter;
                rsp.exp_dec     <= count_zero;
                if (count_zero) begin
                    rsp.product <= partial_product_reg << 1;
                end else begin
                    rsp.product <= partial_product_reg;
                end
            end
        end
    end

    // status outputs
    assign busy        = (state != ST_IDLE);
    assign string_ones = prev_sub;
    assign cycle_count = cycles;

endmodule

// [tb/fmul_checker.sv]
// port checks of the fraction multiply sequencer
`timescale 1ns/10ps
module fmul_checker
    import fmul_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic             start,
    input wire logic             abort,
    input mul_req_t              req,
    input wire logic             busy,
    input wire logic             done,
    input mul_rsp_t              rsp,
    input wire logic             string_ones,
    input wire logic [CYC_W-1:0] cycle_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // request handshake and startup state
    take_start_a: assert property (start && !busy && !abort |=> busy) else $error("start not taken");
    run_zeros_a: assert property ($rose(busy) |-> !string_ones) else $error("run began in ones");
    // completion timing and result
    done_idle_a: assert property (done |-> !busy && $past(busy)) else $error("done outside idle");
    done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
    exp_dec_a: assert property (done |-> rsp.exp_dec == (rsp.final_count == SC_ZERO)) else $error("exp_dec wrong");
    zeros_end_a: assert property (done |-> !string_ones) else $error("ended inside ones");
    rsp_hold_a: assert property (!done |-> $stable(rsp)) else $error("rsp moved without done");
    run_bound_a: assert property ($rose(busy) |-> ##[1:64] !busy) else $error("run too long");
    cycles_a: assert property (done |-> cycle_count != CYC_ZERO) else $error("no run cycles");

    // main scenarios
    cover property (done && rsp.exp_dec);
    cover property (done && !rsp.exp_dec);
    cover property (busy && abort);
    cover property (busy && string_ones);
endmodule

// [tb/fp_microseq.sv]
// model of the microsequencer that loads operands and takes the product
`timescale 1ns/10ps
module fp_microseq
    import fmul_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input mul_req_t  cmd,
    input wire logic done,
    input mul_rsp_t  rsp,
    output logic     start,
    output mul_req_t req,
    output mul_rsp_t got_rsp,
    output logic     got
);
    // one start pulse per command; operands scrambled once handed over
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start   <= 1'b0;
            req     <= '0;
            got     <= 1'b0;
            got_rsp <= '0;
        end else begin
            start <= cmd_valid;
            req   <= cmd_valid ? cmd : mul_req_t'(~req);
            got   <= done;
            if (done) got_rsp <= rsp;
        end
    end
endmodule

// [tb/fraction_multiply_sequencer_bench.sv]
// self-checking bench of the fraction multiply sequencer
`timescale 1ns/10ps
module fraction_multiply_sequencer_bench
    import fmul_pkg::*;
;
    logic             clk = 1'b0;
    logic             rst_b = 1'b0;
    logic             abort = 1'b0;
    logic             cmd_valid = 1'b0;
    mul_req_t         cmd = '0;
    logic             start;
    logic             busy;
    logic             done;
    logic             string_ones;
    logic             got;
    mul_req_t         req;
    mul_rsp_t         rsp;
    mul_rsp_t         got_rsp;
    logic [CYC_W-1:0] cycle_count;
    int               fails = 0;
    int               n_compared = 0;

    always #5 clk = ~clk;

    fraction_multiply_sequencer dut_u (.clk(clk), .rst_b(rst_b), .start(start), .abort(abort), .req(req),
        .busy(busy), .done(done), .rsp(rsp), .string_ones(string_ones), .cycle_count(cycle_count));
    fp_microseq seq_u (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .done(done), .rsp(rsp),
        .start(start), .req(req), .got_rsp(got_rsp), .got(got));

    // reference recoding multiply, one loop pass per run cycle
    function automatic mul_rsp_t ref_mul(input mul_req_t r, output int n);
        logic [REG_W-1:0] acc;
        logic [REG_W-1:0] q;
        logic [SC_W-1:0]  sc;
        logic [WIN_W-1:0] d;
        logic             p;
        int               sh;
        int               k;
        mul_rsp_t         o;
        acc = WORD_ZERO;
        q = r.multiplier;
        p = 1'b0;
        sc = r.dbl ? DP_SC_INIT : SP_SC_INIT;
        n = 0;
        do begin
            d = q[(r.dbl ? DP_WIN_LSB : SP_WIN_LSB) +: WIN_W] ^ {WIN_W{p}};
            k = 6;
            for (int i = 5; i >= 0; i--) if (d[i]) k = i;
            sh = (k == 6) ? 6 : k + 1;
            acc = (acc >> sh) | (p ? ~({REG_W{1'b1}} >> sh) : WORD_ZERO);
            if (k < 6) begin
                acc = (d[k+1] ^ p) ? acc + ~r.multiplicand + WORD_ONE : acc + r.multiplicand;
                p = p ^ d[k+1];
            end
            q = q >> sh;
            sc = sc + sh[SC_W-1:0];
            n++;
        end while ($signed(sc) < 0 || p);
        o.final_count = sc;
        o.exp_dec = (sc == SC_ZERO);
        o.product = o.exp_dec ? acc << 1 : acc;
        return o;
    endfunction

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one command to the microsequencer model
    task automatic issue(input mul_req_t r);
        @(posedge clk);
        #1 cmd_valid = 1'b1;
        cmd = r;
        @(posedge clk);
        #1 cmd_valid = 1'b0;
        cmd = mul_req_t'(~r);
    endtask

    // wait for the product and judge it against the reference
    task automatic collect(input mul_req_t r);
        mul_rsp_t e;
        int       n;
        e = ref_mul(r, n);
        for (int i = 0; i < 200 && got !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check("got", got, 1'b1);
        check("string_ones", string_ones, 1'b0);
        check("product", got_rsp.product, e.product);
        check("final_count", got_rsp.final_count, e.final_count);
        check("exp_dec", got_rsp.exp_dec, e.exp_dec);
        check("cycle_count", cycle_count, (n > 63) ? 63 : n);
    endtask

    task automatic sc_examples;
        mul_req_t r;
        r = '{1'b0, 60'h400000000000000, 60'h680000000000000};
        issue(r);
        collect(r);
        r = '{1'b0, 60'h780000000000000, 60'h440000000000000};
        issue(r);
        collect(r);
    endtask

    task automatic sc_strings;
        logic [REG_W-1:0] m [6] = '{60'h7fffff8000fffff, 60'h7fdfff800000000, 60'h400000800000000,
                                    60'h2aaaaa800000000, 60'h000020000000000, 60'h00003f800000000};
        mul_req_t         r;
        for (int i = 0; i < 6; i++) begin
            r = '{1'b0, 60'h5a0000000000000, m[i]};
            issue(r);
            collect(r);
        end
    endtask

    task automatic sc_double;
        mul_req_t r;
        r = '{1'b1, 60'h600000000000000, 60'h7fffffffffffff8};
        issue(r);
        collect(r);
        r = '{1'b1, 60'h6c0000000000000, 60'h400000000000008};
        issue(r);
        collect(r);
    endtask

    // start while busy is ignored, abort mid-run leaves no trace
    task automatic sc_refuse;
        mul_req_t r;
        r = '{1'b1, 60'h600000000000000, 60'h2aaaaaaaaaaaaa8};
        issue(r);
        issue('{1'b0, 60'h400000000000000, 60'h680000000000000});
        collect(r);
        issue(r);
        repeat (3) @(posedge clk);
        #1 abort = 1'b1;
        @(posedge clk);
        #1 abort = 1'b0;
        check("busy", busy, 1'b0);
        repeat (4) @(posedge clk);
        check("got", got, 1'b0);
        r = '{1'b0, 60'h780000000000000, 60'h680000000000000};
        issue(r);
        collect(r);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1 rst_b = 1'b1;
        sc_examples();
        sc_strings();
        sc_double();
        sc_refuse();
        wrap_up();
    end

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule

bind fraction_multiply_sequencer fmul_checker chk_u (.clk(clk), .rst_b(rst_b), .start(start), .abort(abort),
    .req(req), .busy(busy), .done(done), .rsp(rsp), .string_ones(string_ones), .cycle_count(cycle_count));
